// file: pkg/io_port_defs.vh
`ifndef IO_PORT_DEFS_VH
`define IO_PORT_DEFS_VH

// widths of the port and its change-notice inputs
`define PORT_W        32
`define HALF_W        16
`define CHG_W         24
`define CHG_HI_W      8
`define ADDR_W        8
`define DATA_W        32

// register byte offsets on the apb slave
`define OFS_OUTPUT_LATCH    8'h00
`define OFS_PIN_DIRECTION   8'h04
`define OFS_OPEN_DRAIN      8'h08
`define OFS_PIN_LEVEL       8'h0C
`define OFS_ACFG_LOW_A      8'h10
`define OFS_ACFG_HIGH_A     8'h14
`define OFS_ACFG_LOW_B      8'h18
`define OFS_ACFG_HIGH_B     8'h1C
`define OFS_CHG_EN_LO       8'h20
`define OFS_CHG_EN_HI       8'h24
`define OFS_PULLUP_LO       8'h28
`define OFS_PULLUP_HI       8'h2C
`define OFS_IRQ_STATUS      8'h30
`define OFS_IRQ_MASK        8'h34

// reset values
`define RST_LATCH     32'h0000_0000
`define RST_DIR       32'hFFFF_FFFF
`define RST_OD        32'h0000_0000
`define RST_ACFG      16'h0000
`define RST_EN16      16'h0000
`define RST_EN8       8'h00
`define RST_BIT       1'b0
`define RST_DATA      32'h0000_0000

// field positions
`define IRQ_CHG_BIT   0
`define LO_MSB        15
`define HI_LSB        16

`endif

// file: hdl/pin_driver.v
`timescale 1ns/1ps
// per-pin output stage, analog routing and read masking
module pin_driver
(
    // control from the register file
    input  wire [31:0] latch_in,
    input  wire [31:0] dir_in,
    input  wire [31:0] od_in,
    input  wire [31:0] analog_in,
    // pad side
    input  wire [31:0] pad_in,
    output wire [31:0] pad_out,
    output wire [31:0] pad_oe_n_out,
    output wire [31:0] adc_route_out,
    // level seen by software and change detection
    output wire [31:0] level_out
);

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_pin
            // open drain only ever pulls low; a high latch lets the pin float
            assign pad_out[i]      = od_in[i] ? 1'b0 : latch_in[i]; // RULE1
            // analog selection never touches the driver, so an output pin keeps driving
            assign pad_oe_n_out[i] = dir_in[i] | (od_in[i] & latch_in[i]); // RULE1 RULE3
            // only analog pins reach the converter
            assign adc_route_out[i] = analog_in[i]; // RULE8 RULE3
            // analog pins read as low whatever the pad voltage
            assign level_out[i]    = pad_in[i] & ~analog_in[i]; // RULE7
        end
    endgenerate

endmodule

// file: hdl/change_detect.v
`timescale 1ns/1ps
// compares each change-notice input with its last recorded level
module change_detect
(
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // inputs and their enables
    input  wire [23:0] level_in,
    input  wire [23:0] enable_in,
    // any enabled input differs from its record
    output wire        change_out
);

    reg  [23:0] last_reg;
    wire [23:0] diff;

    genvar i;
    generate
        for (i = 0; i < 24; i = i + 1)
        begin : g_chg
            // record every clock; with the clock stopped the record freezes
            always @(posedge clk_in)
            begin
                if (!rst_n_in)
                    last_reg[i] <= 1'b0;
                else
                    last_reg[i] <= level_in[i]; // RULE16
            end
            // pure gates: a mismatch shows even while no clock runs
            assign diff[i] = (level_in[i] ^ last_reg[i]) & enable_in[i]; // RULE11 RULE13
        end
    endgenerate

    assign change_out = |diff; // RULE16

endmodule

// file: hdl/io_port_pin_control.v
// Notes on behaviour
// RULE1: an open-drain select bit makes its pin pull low only, never drive high
// RULE2: software sets direction to input before using a pin as analog
// RULE3: an analog pin set as output keeps driving; converter samples that level
// RULE4: cleared analog config bit means analog pin, set bit means digital pin
// RULE5: analog config bits reset cleared, so analog-capable pins start analog
// RULE6: a pin is analog when cleared in either converter's config register
// RULE7: pin level reads return zero for every analog pin
// RULE8: digital pins are not routed to the converter
// RULE9: software leaves one cycle between port write or direction change and read
// RULE10: an enabled change-notice input changing raises the interrupt request
// RULE11: change detection works with the clock stopped, for sleep
// RULE12: 24 change-notice inputs, numbered 0 to 23
// RULE13: two enable registers, one bit per input, let a change request interrupt
// RULE14: each change-notice pin has a pull-up enabled by a bit in two registers
// RULE15: software keeps pull-ups off on pins used as digital outputs
// RULE16: change found against last recorded level sets one sticky shared flag
// RULE17: open-drain, change enable and pull-up enable bits reset cleared
`timescale 1ns/1ps
`include "io_port_defs.vh"
module io_port_pin_control
(
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    // pads
    input  wire [31:0] pad_in,
    output wire [31:0] pad_out,
    output wire [31:0] pad_oe_n_out,
    output wire [23:0] weak_pullup_out,
    // converter routing
    output wire [31:0] adc_route_out,
    // interrupt and sleep wake
    output wire        irq_out,
    output wire        wake_out
);

    // software-visible registers; each sits in one aligned word of the bus,
    // narrower ones read their unused upper bits as zero,
    // and only the change-notice enable and pull-up enable registers are trimmed to the 24 inputs
    reg  [31:0] output_latch_reg;
    reg  [31:0] pin_direction_reg;
    reg  [31:0] open_drain_select_reg;
    reg  [15:0] analog_cfg_low_a_reg;
    reg  [15:0] analog_cfg_high_a_reg;
    reg  [15:0] analog_cfg_low_b_reg;
    reg  [15:0] analog_cfg_high_b_reg;
    reg  [15:0] change_irq_enable_lo_reg;
    reg  [7:0]  change_irq_enable_hi_reg;
    reg  [15:0] weak_pullup_enable_lo_reg;
    reg  [7:0]  weak_pullup_enable_hi_reg;
    reg         irq_status_reg;
    reg         irq_mask_reg;
    reg  [31:0] prdata_reg;
    reg  [31:0] prdata_next;

    // derived pin state
    wire [31:0] analog_pin;
    wire [31:0] pin_level;
    wire [23:0] change_enable;
    wire        change_seen;

    // bus decode
    wire        setup_phase;
    wire        access_phase;
    wire        wr_en;
    reg         addr_hit;
    wire        clr_change;

    // a pin is analog unless both converters mark it digital;
    // a pin shared by the two converters therefore goes analog as soon as
    // either side claims it, and software must release it in both
    assign analog_pin = ~({analog_cfg_high_a_reg, analog_cfg_low_a_reg} &
                          {analog_cfg_high_b_reg, analog_cfg_low_b_reg}); // RULE4 RULE6

    // enable bits of inputs 0..23 gathered from the two registers
    assign change_enable = {change_irq_enable_hi_reg, change_irq_enable_lo_reg}; // RULE12

    // each set bit switches that pin's pull-up on
    assign weak_pullup_out = {weak_pullup_enable_hi_reg,
                              weak_pullup_enable_lo_reg}; // RULE14

    // output stage and read masking per pin
    pin_driver u_pin_driver
    (
        .latch_in      (output_latch_reg),
        .dir_in        (pin_direction_reg),
        .od_in         (open_drain_select_reg),
        .analog_in     (analog_pin),
        .pad_in        (pad_in),
        .pad_out       (pad_out),
        .pad_oe_n_out  (pad_oe_n_out),
        .adc_route_out (adc_route_out),
        .level_out     (pin_level)
    );

    // change notice on pins 0..23, masked level so analog pins never fire;
    // turning a pin analog drops its level to zero, so with its enable set
    // that very switch counts as a change; software should disable the
    // input first or clear the flag afterwards
    change_detect u_change_detect
    (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .level_in   (pin_level[`CHG_W-1:0]),
        .enable_in  (change_enable),
        .change_out (change_seen)
    );

    // wake is pure gates so it still works with the clock stopped;
    // the record it compares against froze with the clock, so any enabled
    // pin that moves away from its level at sleep entry raises it at once,
    // and the sticky flag catches up on the first edge after the clock returns
    assign wake_out = change_seen; // RULE11

    // apb phases; zero wait states, the slave always answers at once;
    // writes land at the edge that closes the access phase, reads are taken
    // from a flop loaded in setup, so no combinational path reaches the pins
    // from the bus data
    assign setup_phase  = psel_in & ~penable_in;
    assign access_phase = psel_in & penable_in;
    assign pready_out   = 1'b1;
    assign wr_en        = access_phase & pwrite_in & addr_hit;
    assign pslverr_out  = access_phase & ~addr_hit;
    assign prdata_out   = prdata_reg;

    // address decode and read mux;
    // the pin-level word is read-only: a write to it decodes as a hit so no
    // error is flagged, but no process below has a case for it
    always @*
    begin
        addr_hit    = 1'b1;
        prdata_next = `RST_DATA;
        case (paddr_in)
            `OFS_OUTPUT_LATCH:  prdata_next = output_latch_reg;
            `OFS_PIN_DIRECTION: prdata_next = pin_direction_reg;
            `OFS_OPEN_DRAIN:    prdata_next = open_drain_select_reg;
            // live pad level, already masked for analog pins
            `OFS_PIN_LEVEL:     prdata_next = pin_level; // RULE7 RULE9
            `OFS_ACFG_LOW_A:    prdata_next = {16'h0000, analog_cfg_low_a_reg};
            `OFS_ACFG_HIGH_A:   prdata_next = {16'h0000, analog_cfg_high_a_reg};
            `OFS_ACFG_LOW_B:    prdata_next = {16'h0000, analog_cfg_low_b_reg};
            `OFS_ACFG_HIGH_B:   prdata_next = {16'h0000, analog_cfg_high_b_reg};
            `OFS_CHG_EN_LO:     prdata_next = {16'h0000, change_irq_enable_lo_reg};
            `OFS_CHG_EN_HI:     prdata_next = {24'h00_0000, change_irq_enable_hi_reg};
            `OFS_PULLUP_LO:     prdata_next = {16'h0000, weak_pullup_enable_lo_reg};
            `OFS_PULLUP_HI:     prdata_next = {24'h00_0000, weak_pullup_enable_hi_reg};
            `OFS_IRQ_STATUS:    prdata_next = {31'h0000_0000, irq_status_reg};
            `OFS_IRQ_MASK:      prdata_next = {31'h0000_0000, irq_mask_reg};
            default:
            begin
                // unmapped: read zero and flag an error
                addr_hit    = 1'b0;
                prdata_next = `RST_DATA;
            end
        endcase
    end

    // read data captured in the setup cycle so it is a flop in the access cycle;
    // this is also why a pin read sees the pad one cycle before completion
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            prdata_reg <= `RST_DATA;
        else if (setup_phase && !pwrite_in)
            prdata_reg <= prdata_next;
    end

    // port data, direction and open-drain registers;
    // direction resets to all inputs so nothing is driven before software
    // has set the latch, and open-drain resets off so a later switch to
    // output starts as a plain push-pull driver
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            output_latch_reg      <= `RST_LATCH;
            pin_direction_reg     <= `RST_DIR;
            open_drain_select_reg <= `RST_OD; // RULE17
        end
        else if (wr_en)
        begin
            case (paddr_in)
                `OFS_OUTPUT_LATCH:  output_latch_reg      <= pwdata_in;
                `OFS_PIN_DIRECTION: pin_direction_reg     <= pwdata_in;
                `OFS_OPEN_DRAIN:    open_drain_select_reg <= pwdata_in; // RULE1
                default:
                begin
                    output_latch_reg <= output_latch_reg;
                end
            endcase
        end
    end

    // analog configuration for both converters; cleared bits mean analog;
    // resetting to analog keeps the digital input buffers out of the way of
    // whatever voltage sits on the pins until software decides otherwise;
    // upper halves of the bus word are ignored
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            analog_cfg_low_a_reg  <= `RST_ACFG; // RULE5
            analog_cfg_high_a_reg <= `RST_ACFG; // RULE5
            analog_cfg_low_b_reg  <= `RST_ACFG; // RULE5
            analog_cfg_high_b_reg <= `RST_ACFG; // RULE5
        end
        else if (wr_en)
        begin
            case (paddr_in)
                `OFS_ACFG_LOW_A:  analog_cfg_low_a_reg  <= pwdata_in[`LO_MSB:0]; // RULE4
                `OFS_ACFG_HIGH_A: analog_cfg_high_a_reg <= pwdata_in[`LO_MSB:0]; // RULE4
                `OFS_ACFG_LOW_B:  analog_cfg_low_b_reg  <= pwdata_in[`LO_MSB:0]; // RULE4
                `OFS_ACFG_HIGH_B: analog_cfg_high_b_reg <= pwdata_in[`LO_MSB:0]; // RULE4
                default:
                begin
                    analog_cfg_low_a_reg <= analog_cfg_low_a_reg;
                end
            endcase
        end
    end

    // change-notice enables and pull-up enables; upper bits of the hi words ignored;
    // pull-ups are not gated by direction, so a pull-up left on under a
    // driven output simply fights the driver and wastes current
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            change_irq_enable_lo_reg  <= `RST_EN16; // RULE17
            change_irq_enable_hi_reg  <= `RST_EN8; // RULE17
            weak_pullup_enable_lo_reg <= `RST_EN16; // RULE17
            weak_pullup_enable_hi_reg <= `RST_EN8; // RULE17
        end
        else if (wr_en)
        begin
            case (paddr_in)
                `OFS_CHG_EN_LO: change_irq_enable_lo_reg <= pwdata_in[`LO_MSB:0]; // RULE13
                `OFS_CHG_EN_HI: change_irq_enable_hi_reg <= pwdata_in[`CHG_HI_W-1:0]; // RULE13
                `OFS_PULLUP_LO: weak_pullup_enable_lo_reg <= pwdata_in[`LO_MSB:0]; // RULE14
                `OFS_PULLUP_HI: weak_pullup_enable_hi_reg <= pwdata_in[`CHG_HI_W-1:0]; // RULE14
                default:
                begin
                    change_irq_enable_lo_reg <= change_irq_enable_lo_reg;
                end
            endcase
        end
    end

    // write one to clear the sticky change flag
    assign clr_change = wr_en && (paddr_in == `OFS_IRQ_STATUS) &&
                        pwdata_in[`IRQ_CHG_BIT];

    // sticky shared change flag; a change in the clearing cycle wins over the clear;
    // losing that event would hide a pin edge from software for good, while
    // an extra interrupt only costs one more status read
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            irq_status_reg <= `RST_BIT;
        else if (change_seen)
            irq_status_reg <= 1'b1; // RULE16 RULE10
        else if (clr_change)
            irq_status_reg <= 1'b0; // RULE16
    end

    // interrupt mask; a masked flag still records changes and still shows
    // in the status word, so software may poll with the interrupt off
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            irq_mask_reg <= `RST_BIT;
        else if (wr_en && (paddr_in == `OFS_IRQ_MASK))
            irq_mask_reg <= pwdata_in[`IRQ_CHG_BIT];
    end

    // level interrupt while the flag is set and unmasked;
    // it drops in the cycle after the clear unless a new change arrived,
    // which keeps the request up with no gap
    assign irq_out = irq_status_reg & irq_mask_reg; // RULE10

endmodule

// file: testbench/io_port_pin_control_asserts.sv
`timescale 1ns/1ps
// port-level checks of the pin control block, one clock domain
module io_port_pin_control_chk
(
    // clock, reset and apb
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] prdata_out,
    // pads and events
    input  wire logic [31:0] pad_in,
    input  wire logic [31:0] pad_oe_n_out,
    input  wire logic [23:0] weak_pullup_out,
    input  wire logic [31:0] adc_route_out,
    input  wire logic        irq_out,
    input  wire logic        wake_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // a write lands at the edge closing its access phase
    wire wr_acc = psel_in & penable_in & pwrite_in;

    reset_vals_a: assert property (disable iff (1'b0)
        !rst_n_in |=> pad_oe_n_out == '1 && adc_route_out == '1 && weak_pullup_out == '0 && !irq_out)
        else $error("reset values wrong");
    level_read_a: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == 8'h0C
        |=> prdata_out == ($past(pad_in) & ~$past(adc_route_out)))
        else $error("pin level read wrong");
    route_hold_a: assert property ($changed(adc_route_out)
        |-> $past(wr_acc) || !$past(rst_n_in)) else $error("routing moved without write");
    pull_hold_a: assert property ($changed(weak_pullup_out)
        |-> $past(wr_acc) || !$past(rst_n_in)) else $error("pull-up moved without write");
    drive_hold_a: assert property ($changed(pad_oe_n_out)
        |-> $past(wr_acc) || !$past(rst_n_in)) else $error("drive moved without write");
    irq_cause_a: assert property ($rose(irq_out)
        |-> $past(wake_out) || $past(wr_acc)) else $error("irq rose without cause");
    irq_sticky_a: assert property (irq_out && !wr_acc |=> irq_out)
        else $error("irq dropped without write");
    wake_quiet_a: assert property ($stable(pad_in) && !$past(wr_acc) |-> !wake_out)
        else $error("wake with quiet pins");
endmodule

bind io_port_pin_control io_port_pin_control_chk chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pad_in(pad_in), .pad_oe_n_out(pad_oe_n_out),
    .weak_pullup_out(weak_pullup_out), .adc_route_out(adc_route_out), .irq_out(irq_out),
    .wake_out(wake_out));

// file: testbench/pin_world.sv
`timescale 1ns/1ps
// board around the pins; a floating pin shows the inverse of the device data
// so the simulator never quietly settles it to a lucky level
module pin_world
(
    // device side
    input  wire [31:0] pad_data_in,
    input  wire [31:0] pad_oe_n_in,
    input  wire [23:0] pullup_in,
    // board side
    input  wire [31:0] ext_val_in,
    input  wire [31:0] ext_en_in,
    output wire [31:0] level_out
);
    wire [31:0] pu = {8'h00, pullup_in};
    // device drive wins, then a board driver, then the weak pull-up
    assign level_out = (~pad_oe_n_in & pad_data_in) | (pad_oe_n_in & ext_en_in & ext_val_in)
                     | (pad_oe_n_in & ~ext_en_in & (pu | ~pad_data_in));
endmodule

// file: testbench/test_io_port_pin_control.sv
`timescale 1ns/1ps
`include "io_port_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module test_io_port_pin_control;
    typedef struct packed { logic [7:0] a; logic [31:0] r, w, b; } row_t;
    localparam logic [31:0] F = 32'hFFFF_FFFF;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, pad_in, pad_out, pad_oe_n_out, adc_route_out;
    logic [31:0] ext_val, ext_en, rdata;
    logic [23:0] weak_pullup_out;
    logic        pready_out, pslverr_out, irq_out, wake_out, last_err;
    int          err_count = 0;
    int          checks = 0;
    row_t        rows [12];

    io_port_pin_control uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n_out), .weak_pullup_out(weak_pullup_out),
        .adc_route_out(adc_route_out), .irq_out(irq_out), .wake_out(wake_out));
    pin_world board (.pad_data_in(pad_out), .pad_oe_n_in(pad_oe_n_out),
        .pullup_in(weak_pullup_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pad_in));

    // one apb transfer; the idle edge before setup also spaces a write from a read
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'b1);
        rdata = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, Z);
        `CHK(rdata, e)
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // watchdog, far above the few hundred cycles the tests need
    initial
    begin
        #100000;
        err_count++;
        give_verdict;
    end

    // reset value, write, readback of each register except pin level and irq status
    initial
    begin
        // pins 0..23 carry the pull-ups and stay inputs for the whole run
        rows = '{'{`OFS_OUTPUT_LATCH, Z, F, F},
            '{`OFS_PIN_DIRECTION, F, 32'h00FF_FFFF, 32'h00FF_FFFF},
            '{`OFS_OPEN_DRAIN, Z, F, F},
            '{`OFS_ACFG_LOW_A, Z, F, 32'h0000_FFFF},
            '{`OFS_ACFG_HIGH_A, Z, F, 32'h0000_FFFF},
            '{`OFS_ACFG_LOW_B, Z, F, 32'h0000_FFFF},
            '{`OFS_ACFG_HIGH_B, Z, F, 32'h0000_FFFF},
            '{`OFS_CHG_EN_LO, Z, F, 32'h0000_FFFF},
            '{`OFS_CHG_EN_HI, Z, F, 32'h0000_00FF},
            '{`OFS_PULLUP_LO, Z, F, 32'h0000_FFFF},
            '{`OFS_PULLUP_HI, Z, F, 32'h0000_00FF},
            '{`OFS_IRQ_MASK, Z, F, 32'h0000_0001}};
        rst_n_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = Z;
        ext_val = Z;
        ext_en = Z;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i].a, rows[i].r);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].b);
        end
        $display("register rows done");
        // pins 24..31 are outputs; pin 24 analog yet driven, pins 0 and 1 analog as inputs
        wr(`OFS_OPEN_DRAIN, 32'h3000_0000);
        wr(`OFS_OUTPUT_LATCH, 32'h3C00_0000);
        wr(`OFS_ACFG_LOW_A, 32'h0000_FFFE);
        wr(`OFS_ACFG_LOW_B, 32'h0000_FFFD);
        wr(`OFS_ACFG_HIGH_A, 32'h0000_FEFF);
        // board drives all but pin 6, which rests on its pull-up; pin level is read-only
        ext_en <= 32'hFFFF_FFBF;
        ext_val <= 32'hA5A5_A5A5;
        // outputs follow the registers written at the last edge; look once they settle
        @(negedge clk_in);
        `CHK(pad_out, 32'h0C00_0000)
        `CHK(pad_oe_n_out, 32'h30FF_FFFF)
        `CHK(adc_route_out, 32'h0100_0003)
        wr(`OFS_PIN_LEVEL, F);
        rd(`OFS_PIN_LEVEL, 32'h2CA5_A5E4);
        rd(8'h40, Z);
        `CHK(last_err, 1'b1)
        $display("pin tests done");
        // change notice on pin 4, then a disabled pin, then pin 23
        wr(`OFS_CHG_EN_LO, 32'h0000_0010);
        wr(`OFS_CHG_EN_HI, Z);
        wr(`OFS_IRQ_STATUS, 32'h0000_0001);
        @(negedge clk_in);
        `CHK(irq_out, 1'b0)
        @(posedge clk_in);
        ext_val <= ext_val ^ 32'h0000_0010;
        @(negedge clk_in);
        `CHK(wake_out, 1'b1)
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK(irq_out, 1'b1)
        `CHK(wake_out, 1'b0)
        wr(`OFS_IRQ_STATUS, 32'h0000_0001);
        ext_val <= ext_val ^ 32'h0000_0020;
        @(negedge clk_in);
        `CHK(irq_out, 1'b0)
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(irq_out, 1'b0)
        wr(`OFS_CHG_EN_HI, 32'h0000_0080);
        ext_val <= ext_val ^ 32'h0080_0000;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(irq_out, 1'b1)
        wr(`OFS_IRQ_MASK, Z);
        @(negedge clk_in);
        `CHK(irq_out, 1'b0)
        rd(`OFS_IRQ_STATUS, 32'h0000_0001);
        $display("change notice done");
        // second reset in mid-run
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(adc_route_out, F)
        `CHK(weak_pullup_out, 24'h00_0000)
        `CHK(pad_oe_n_out, F)
        `CHK(irq_out, 1'b0)
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`OFS_OPEN_DRAIN, Z);
        $display("reset test done");
        give_verdict;
    end
endmodule
